// *** src/vlf_pkg.sv ***
/*
 * vlf_pkg: command codes, reset values, field positions and shared types for the
 * output-voltage limit and low-voltage fault reaction block.
 * Assumes a PMBus command decoder upstream that hands over whole command writes and reads.
 */
package vlf_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_HI_WARN = 8'h42;
    localparam logic [7:0] CMD_LO_WARN = 8'h43;
    localparam logic [7:0] CMD_LO_FAULT = 8'h44;
    localparam logic [7:0] CMD_LO_REACT = 8'h45;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_HI_WARN = 16'h0000;
    localparam logic [15:0] RST_LO_WARN = 16'h0000;
    localparam logic [15:0] RST_LO_FAULT = 16'h0000;
    localparam logic [7:0] RST_LO_REACT = 8'h00;

    // ------------------------------------------------------------
    // reaction field positions and codes
    // ------------------------------------------------------------
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI = 2;
    localparam int DLY_LO = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RIDE = 2'h1;
    localparam logic [1:0] RESP_SHUT = 2'h2;
    localparam logic [1:0] RESP_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // cycles of the restart attempt window
    localparam int ATTEMPT_CYC = 4;

    // host access as handed over by the command decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } vlf_req_t;

    // fault sequencer state, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_RIDE = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_TRY = 5'b01000,
        ST_LATCH = 5'b10000
    } vlf_state_t;

endpackage

// *** src/vlf_delay.sv ***
/*
 * vlf_delay: counts 2^code time units; unit ticks come from a divider enable.
 * Assumes start is a one-cycle pulse and tick_i is a one-cycle enable.
 */
`timescale 1ns/1ps
module vlf_delay (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [2:0] code_i,
    input wire logic tick_i,
    output logic done_o
);
    logic [7:0] cnt_q;
    logic run_q;

    // ------------------------------------------------------------
    // unit counter
    // ------------------------------------------------------------
    // code to power-of-two units
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || abort_i) begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
            done_o <= 1'b0;
        end else if (start_i) begin
            run_q <= 1'b1;
            cnt_q <= 8'(8'h01 << code_i);
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (run_q && tick_i) begin
                if (cnt_q == 8'h01) begin
                    run_q <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// *** src/vlf_top.sv ***
/*
 * vlf_top: output-voltage warning/fault limits and the low-voltage fault reaction.
 * Assumes a command decoder delivering one-cycle wr/rd strobes, a measured output
 * voltage in the same format as the limits, and a time-unit divider count from elsewhere.
 */
`timescale 1ns/1ps
module vlf_top #(
    parameter int UNIT_CYC = 20000
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input vlf_pkg::vlf_req_t req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    input wire logic [15:0] vout_meas_i,
    input wire logic clear_faults_i,
    input wire logic clear_bit_i,
    input wire logic power_on_i,
    output logic out_en_o,
    output logic fault_latched_o,
    output logic fault_now_o,
    output logic warn_hi_o,
    output logic warn_lo_o
);
    logic [15:0] hi_warn_q;
    logic [15:0] lo_warn_q;
    logic [15:0] lo_fault_q;
    logic [7:0] react_q;
    logic [31:0] div_q;
    logic tick;
    logic fault;
    logic [2:0] tries_q;
    logic [7:0] try_cnt_q;
    logic on_q;
    logic clear_ev;
    logic dly_start;
    logic dly_done;
    logic [1:0] resp;
    logic [2:0] retry;
    vlf_pkg::vlf_state_t st_q;

    assign resp = react_q[vlf_pkg::RESP_HI:vlf_pkg::RESP_LO];
    assign retry = react_q[vlf_pkg::RETRY_HI:vlf_pkg::RETRY_LO];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // limit and reaction register stores
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            hi_warn_q <= vlf_pkg::RST_HI_WARN;
            lo_warn_q <= vlf_pkg::RST_LO_WARN;
            lo_fault_q <= vlf_pkg::RST_LO_FAULT;
            react_q <= vlf_pkg::RST_LO_REACT;
        end else if (req_i.wr) begin
            if (req_i.cmd == vlf_pkg::CMD_HI_WARN) begin
                hi_warn_q <= req_i.wdata;
            end else if (req_i.cmd == vlf_pkg::CMD_LO_WARN) begin
                lo_warn_q <= req_i.wdata;
            end else if (req_i.cmd == vlf_pkg::CMD_LO_FAULT) begin
                lo_fault_q <= req_i.wdata;
            end else if (req_i.cmd == vlf_pkg::CMD_LO_REACT) begin
                react_q <= req_i.wdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // register reads, one cycle after the strobe
    // ------------------------------------------------------------
    // byte read zero-extended
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                if (req_i.cmd == vlf_pkg::CMD_HI_WARN) begin
                    rdata_o <= hi_warn_q;
                end else if (req_i.cmd == vlf_pkg::CMD_LO_WARN) begin
                    rdata_o <= lo_warn_q;
                end else if (req_i.cmd == vlf_pkg::CMD_LO_FAULT) begin
                    rdata_o <= lo_fault_q;
                end else if (req_i.cmd == vlf_pkg::CMD_LO_REACT) begin
                    rdata_o <= {8'h00, react_q};
                end else begin
                    rdata_o <= 16'h0000; // unmapped
                end
            end
        end
    end

    // ------------------------------------------------------------
    // compare and warnings
    // ------------------------------------------------------------
    // below fault limit
    assign fault = vout_meas_i < lo_fault_q;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            warn_hi_o <= 1'b0;
            warn_lo_o <= 1'b0;
            fault_now_o <= 1'b0;
        end else begin
            warn_hi_o <= vout_meas_i > hi_warn_q;
            warn_lo_o <= vout_meas_i < lo_warn_q;
            fault_now_o <= fault;
        end
    end

    // ------------------------------------------------------------
    // time unit divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || dly_start) begin
            div_q <= 32'h0;
        end else if (div_q == 32'(UNIT_CYC - 1)) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end
    assign tick = (div_q == 32'(UNIT_CYC - 1));

    // ------------------------------------------------------------
    // off-then-on detection and clear events
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            on_q <= 1'b0;
        end else begin
            on_q <= power_on_i;
        end
    end
    assign clear_ev = clear_faults_i || clear_bit_i || (power_on_i && !on_q);

    // ------------------------------------------------------------
    // fault sequencer
    // ------------------------------------------------------------
    assign dly_start = (st_q == vlf_pkg::ST_RUN) && fault
        && (resp == vlf_pkg::RESP_RIDE || resp == vlf_pkg::RESP_SHUT)
        || (st_q == vlf_pkg::ST_TRY) && try_cnt_q == 8'h01 && fault
        && (retry == vlf_pkg::RETRY_FOREVER || tries_q != retry)
        || (st_q == vlf_pkg::ST_RIDE) && dly_done && fault
        && (retry != vlf_pkg::RETRY_NONE); // ride expired: space the first restart

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !power_on_i) begin
            st_q <= vlf_pkg::ST_RUN;
            tries_q <= 3'h0;
            try_cnt_q <= 8'h00;
        end else begin
            case (st_q)
                vlf_pkg::ST_RUN: begin
                    tries_q <= 3'h0;
                    if (fault && resp == vlf_pkg::RESP_HOLD) begin
                        st_q <= vlf_pkg::ST_LATCH;
                    end else if (fault && resp == vlf_pkg::RESP_RIDE) begin
                        st_q <= vlf_pkg::ST_RIDE; // ride delay
                    end else if (fault && resp == vlf_pkg::RESP_SHUT) begin
                        st_q <= (retry == vlf_pkg::RETRY_NONE) ? vlf_pkg::ST_LATCH
                            : vlf_pkg::ST_WAIT;
                    end
                end
                vlf_pkg::ST_RIDE: begin
                    if (!fault) begin
                        st_q <= vlf_pkg::ST_RUN;
                    end else if (dly_done) begin
                        st_q <= (retry == vlf_pkg::RETRY_NONE) ? vlf_pkg::ST_LATCH
                            : vlf_pkg::ST_WAIT;
                    end
                end
                vlf_pkg::ST_WAIT: begin
                    if (dly_done) begin
                        st_q <= vlf_pkg::ST_TRY;
                        try_cnt_q <= 8'(vlf_pkg::ATTEMPT_CYC);
                        if (tries_q != 3'h7) begin
                            tries_q <= tries_q + 3'h1;
                        end
                    end
                end
                vlf_pkg::ST_TRY: begin
                    try_cnt_q <= try_cnt_q - 8'h01;
                    if (try_cnt_q == 8'h01) begin
                        if (!fault) begin
                            st_q <= vlf_pkg::ST_RUN;
                        end else if (dly_start) begin
                            st_q <= vlf_pkg::ST_WAIT;
                        end else begin
                            st_q <= vlf_pkg::ST_LATCH;
                        end
                    end
                end
                vlf_pkg::ST_LATCH: begin
                    if (resp == vlf_pkg::RESP_HOLD && !fault) begin
                        st_q <= vlf_pkg::ST_RUN;
                    end else if (clear_ev) begin
                        st_q <= vlf_pkg::ST_RUN; // cleared
                    end
                end
                default: begin
                    st_q <= vlf_pkg::ST_RUN;
                end
            endcase
        end
    end

    vlf_delay u_delay (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .start_i(dly_start),
        .abort_i(!power_on_i || (st_q == vlf_pkg::ST_RIDE && !fault)),
        .code_i(react_q[vlf_pkg::DLY_HI:vlf_pkg::DLY_LO]),
        .tick_i(tick),
        .done_o(dly_done)
    );

    assign out_en_o = power_on_i && (st_q == vlf_pkg::ST_RUN || st_q == vlf_pkg::ST_RIDE
        || st_q == vlf_pkg::ST_TRY);
    assign fault_latched_o = (st_q == vlf_pkg::ST_LATCH);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ignore;
        @(posedge clk_sys_i) disable iff (srst_i)
        (st_q == vlf_pkg::ST_RUN && resp == vlf_pkg::RESP_IGNORE && power_on_i)
        |=> st_q == vlf_pkg::ST_RUN;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore left run");

    property p_shut;
        @(posedge clk_sys_i) disable iff (srst_i)
        (st_q == vlf_pkg::ST_RUN && fault && resp == vlf_pkg::RESP_SHUT && power_on_i)
        |=> !out_en_o;
    endproperty
    a_shut: assert property (p_shut) else $error("output not shut");

    property p_hold;
        @(posedge clk_sys_i) disable iff (srst_i)
        (st_q == vlf_pkg::ST_LATCH && resp == vlf_pkg::RESP_HOLD && !fault && power_on_i)
        |=> out_en_o;
    endproperty
    a_hold: assert property (p_hold) else $error("no resume");

    property p_wr_lo_fault;
        @(posedge clk_sys_i) disable iff (srst_i)
        (req_i.wr && req_i.cmd == vlf_pkg::CMD_LO_FAULT) |=> lo_fault_q == $past(req_i.wdata);
    endproperty
    a_wr_lo_fault: assert property (p_wr_lo_fault) else $error("limit not stored");

    property p_byte_rd;
        @(posedge clk_sys_i) disable iff (srst_i)
        (req_i.rd && req_i.cmd == vlf_pkg::CMD_LO_REACT) |=> rdata_o[15:8] == 8'h00;
    endproperty
    a_byte_rd: assert property (p_byte_rd) else $error("byte read wide");

    property p_noretry;
        @(posedge clk_sys_i) disable iff (srst_i)
        (st_q == vlf_pkg::ST_RUN && fault && resp == vlf_pkg::RESP_SHUT
        && retry == vlf_pkg::RETRY_NONE && power_on_i) |=> st_q == vlf_pkg::ST_LATCH;
    endproperty
    a_noretry: assert property (p_noretry) else $error("no-retry not latched");

    property p_clear;
        @(posedge clk_sys_i) disable iff (srst_i)
        (st_q == vlf_pkg::ST_LATCH && clear_faults_i && power_on_i)
        |=> st_q == vlf_pkg::ST_RUN;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    property p_rd_lat;
        @(posedge clk_sys_i) disable iff (srst_i)
        req_i.rd |=> rvalid_o;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule

// *** test/vlf_host_model.sv ***
/*
 * vlf_host_model: host that issues register writes and reads to vlf_top.
 * Assumes one-cycle strobes, driven at the falling edge of clk_sys_i.
 */
`timescale 1ns/1ps
module vlf_host_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output vlf_pkg::vlf_req_t req_o
);
    // ----------------------------------------
    // idle request
    // ----------------------------------------
    initial begin
        req_o = '0;
    end

    task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge clk_sys_i);
        req_o.cmd = cmd;
        // byte transfer has no upper byte, so junk rides there
        req_o.wdata = (cmd == vlf_pkg::CMD_LO_REACT) ? {~data[7:0], data[7:0]} : data;
        req_o.wr = 1'b1;
        @(negedge clk_sys_i);
        req_o.wr = 1'b0;
        req_o.wdata = ~req_o.wdata; // released data no longer valid
    endtask

    // read strobe, then bounded wait for the answer
    task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data, output bit ok);
        ok = 1'b0;
        data = '0;
        @(negedge clk_sys_i);
        req_o.cmd = cmd;
        req_o.rd = 1'b1;
        @(negedge clk_sys_i);
        req_o.rd = 1'b0;
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rvalid_i === 1'b1) begin
                data = rdata_i;
                ok = 1'b1;
            end else begin
                @(negedge clk_sys_i);
            end
        end
    endtask
endmodule

// *** test/tb_vout_limit_fault_response.sv ***
/*
 * tb_vout_limit_fault_response: self-checking bench for vlf_top.
 * Assumes vlf_pkg, vlf_top and vlf_host_model are compiled first.
 */
`timescale 1ns/1ps
module tb_vout_limit_fault_response;
    localparam int UNIT = 4;
    logic clk_sys_i;
    logic srst_i;
    vlf_pkg::vlf_req_t req;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] vout;
    logic clr_faults;
    logic clr_bit;
    logic pwr_on;
    logic out_en;
    logic latched;
    logic flt_now;
    logic warn_hi;
    logic warn_lo;
    int failures;
    int compares;
    logic [15:0] lfsr_q;
    int cnt;
    int gmin;
    int gmax;
    int t;
    int d;

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    vlf_top #(.UNIT_CYC(UNIT)) dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .vout_meas_i(vout), .clear_faults_i(clr_faults),
        .clear_bit_i(clr_bit), .power_on_i(pwr_on), .out_en_o(out_en),
        .fault_latched_o(latched), .fault_now_o(flt_now), .warn_hi_o(warn_hi),
        .warn_lo_o(warn_lo));

    vlf_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .req_o(req));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic int dly_cyc(input int code);
        return UNIT << code;
    endfunction

    task automatic summarize();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] got;
        bit ok;
        host_u.read_reg(cmd, got, ok);
        if (!ok) begin
            failures++;
            summarize();
        end
        check(got, exp);
    endtask

    // off-on cycle with a fresh reaction setting, healthy output
    task automatic restart(input logic [7:0] react);
        vout = 16'hffff;
        pwr_on = 1'b0;
        host_u.write_reg(vlf_pkg::CMD_LO_REACT, react);
        cyc(2);
        pwr_on = 1'b1;
        cyc(3);
    endtask

    // count enable rises and the spacing between them
    task automatic watch(input int win, output int cnt, output int gmin, output int gmax);
        logic prev;
        int last;
        prev = out_en;
        last = -1;
        cnt = 0;
        gmin = 1 << 20;
        gmax = 0;
        for (int i = 0; i < win; i++) begin
            @(negedge clk_sys_i);
            if (out_en === 1'b1 && prev !== 1'b1) begin
                cnt++;
                if (last >= 0) begin
                    gmin = (i - last < gmin) ? i - last : gmin;
                    gmax = (i - last > gmax) ? i - last : gmax;
                end
                last = i;
            end
            prev = out_en;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        failures = 0;
        compares = 0;
        lfsr_q = 16'h0040;
        srst_i = 1'b1;
        vout = 16'hffff;
        clr_faults = 1'b0;
        clr_bit = 1'b0;
        pwr_on = 1'b1;
        cyc(10);
        srst_i = 1'b0;
        cyc(1);
        for (int c = 0; c < 4; c++) begin
            rd_chk(8'h42 + c[7:0], 16'h0000);
        end
        for (int n = 0; n < 6; n++) begin
            for (int c = 0; c < 4; c++) begin
                lfsr_q = lfsr_next(lfsr_q);
                host_u.write_reg(8'h42 + c[7:0], lfsr_q);
                rd_chk(8'h42 + c[7:0], (c == 3) ? {8'h00, lfsr_q[7:0]} : lfsr_q);
            end
        end
        host_u.write_reg(8'h46, 16'h5a5a);
        rd_chk(8'h46, 16'h0000);
        $display("test registers done");
        host_u.write_reg(vlf_pkg::CMD_HI_WARN, 16'h3000);
        host_u.write_reg(vlf_pkg::CMD_LO_WARN, 16'h2000);
        host_u.write_reg(vlf_pkg::CMD_LO_FAULT, 16'h1000);
        vout = 16'h3800;
        cyc(3);
        check({warn_hi, warn_lo, flt_now}, 3'b100);
        vout = 16'h1800;
        cyc(3);
        check({warn_hi, warn_lo, flt_now}, 3'b010);
        vout = 16'h0800;
        cyc(3);
        check({warn_hi, warn_lo, flt_now}, 3'b011);
        $display("test compares done");
        restart(8'h00);
        vout = 16'h0800;
        cyc(40);
        check({out_en, latched}, 2'b10);
        restart(8'hc0);
        vout = 16'h0800;
        cyc(4);
        check(out_en, 1'b0);
        vout = 16'hffff;
        cyc(4);
        check(out_en, 1'b1);
        $display("test ignore and hold done");
        for (int k = 0; k < 3; k++) begin
            restart(8'h80);
            vout = 16'h0800;
            cyc(4);
            check({out_en, latched}, 2'b01);
            vout = 16'hffff;
            cyc(40);
            check({out_en, latched}, 2'b01);
            clr_faults = (k == 0);
            clr_bit = (k == 1);
            pwr_on = (k != 2);
            cyc(2);
            clr_faults = 1'b0;
            clr_bit = 1'b0;
            pwr_on = 1'b1;
            cyc(4);
            check({out_en, latched}, 2'b10);
        end
        $display("test clears done");
        for (int n = 1; n <= 6; n++) begin
            d = n % 3;
            restart({2'b10, n[2:0], d[2:0]});
            vout = 16'h0800;
            watch((n + 1) * (dly_cyc(d) + 8) + 20, cnt, gmin, gmax);
            check(cnt, n);
            check(latched, 1'b1);
            if (n > 1) begin
                check(gmin >= dly_cyc(d) && gmax <= dly_cyc(d) + vlf_pkg::ATTEMPT_CYC + 2, 1);
            end
        end
        restart(8'hb8);
        vout = 16'h0800;
        watch(200, cnt, gmin, gmax);
        check(cnt > 10 && latched === 1'b0, 1);
        $display("test retries done");
        for (int c = 0; c < 8; c++) begin
            restart({5'b01000, c[2:0]});
            vout = 16'h0800;
            t = 0;
            while (out_en === 1'b1 && t < 600) begin
                cyc(1);
                t++;
            end
            check(t >= dly_cyc(c) && t <= dly_cyc(c) + 3, 1);
            if (t >= 600) begin
                summarize();
            end
        end
        // ride, then one restart attempt that fails
        restart(8'h48);
        vout = 16'h0800;
        watch(80, cnt, gmin, gmax);
        check(cnt, 1);
        check(latched, 1'b1);
        restart(8'h43);
        vout = 16'h0800;
        cyc(10);
        vout = 16'hffff;
        cyc(60);
        check({out_en, latched}, 2'b10);
        $display("test ride done");
        summarize();
    end
endmodule
